// ---- logic/tam_alarm_top.sv ----
// alarm status, masks and the two alarm pins of the eight-channel monitor,
// with the two-wire byte slave that reaches the registers.
// assumes the conversion engine supplies per-channel comparison results on its
// own clock, with a done pulse at the end of each conversion round.
`timescale 1ns/1ps
`default_nettype none

module tam_alarm_top
    import tam_pkg::*;
#(
    parameter logic [6:0] OWN_ADDR = 7'h4D  // slave address, value arbitrary
)
(
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic              conv_clk_i,
    input  wire logic              conv_done_i,
    input  wire logic [NCH-1:0]    high_cmp_i,
    input  wire logic [NCH-1:0]    low_cmp_i,
    input  wire logic [NCH-1:0]    ovt_cmp_i,
    input  wire logic [NCH-1:0]    ovt_hyst_i,
    input  wire logic [NFAULT-1:0] fault_i,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output var  logic              sda_o,
    output var  logic              sda_oe_n_o,
    output var  logic              alert_o,
    output var  logic              alert_oe_n_o,
    output var  logic              overt_o,
    output var  logic              overt_oe_n_o,
    output var  logic [NCH-1:0]    low_warning_o
);

    // conversion results in channel order, then in register bit order
    logic              conv_evt;
    logic [NCH-1:0]    high_ch;
    logic [NCH-1:0]    low_ch;
    logic [NCH-1:0]    ovt_ch;
    logic [NCH-1:0]    hyst_ch;
    logic [NFAULT-1:0] fault_ch;
    logic [NCH-1:0]    high_map;
    logic [NCH-1:0]    low_map;
    logic [NCH-1:0]    ovt_map;
    logic [NCH-1:0]    hyst_map;

    // registers and alarm state
    logic [7:0]        alert_mask;
    logic [7:0]        overtemp_channel_mask;
    logic [7:0]        high_warning_status;
    logic [7:0]        overtemp_status;
    logic [7:0]        sensor_fault_status;
    logic [7:0]        next_overtemp_status;
    logic              alert_active;

    // two-wire engine
    logic [1:0]        pins_sync;
    logic              scl_s;
    logic              sda_s;
    logic              scl_d;
    logic              sda_d;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_cond;
    logic              stop_cond;
    tam_state_t        state;
    logic [7:0]        shreg;
    logic [7:0]        byte_in;
    logic [3:0]        bitcnt;
    logic [7:0]        pointer;
    logic [7:0]        tx;
    logic [7:0]        read_data;
    logic              rw;
    logic              is_ara;
    logic              ack_ok;
    logic              ack_phase;
    logic              master_nack;
    logic              wr_pulse;
    logic [7:0]        wr_data;
    logic              hs_clear;
    logic              ara_clear;

    tam_conv_cdc u_conv_cdc (
        .conv_clk_i  (conv_clk_i),
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .conv_done_i (conv_done_i),
        .high_cmp_i  (high_cmp_i),
        .low_cmp_i   (low_cmp_i),
        .ovt_cmp_i   (ovt_cmp_i),
        .ovt_hyst_i  (ovt_hyst_i),
        .fault_i     (fault_i),
        .conv_evt_o  (conv_evt),
        .high_cmp_o  (high_ch),
        .low_cmp_o   (low_ch),
        .ovt_cmp_o   (ovt_ch),
        .ovt_hyst_o  (hyst_ch),
        .fault_o     (fault_ch)
    );

    // channel 0 is local and lands on bit 6; remote 7 on bit 7; remote n on n-1
    for (genvar c = 0; c < NCH; c++)
    begin : g_chan
        localparam int unsigned POS = (c == 0) ? LOCAL_BIT : ((c == 7) ? REMOTE7_BIT : c - 1);
        assign high_map[POS] = high_ch[c];
        assign low_map[POS]  = low_ch[c];
        assign ovt_map[POS]  = ovt_ch[c];
        assign hyst_map[POS] = hyst_ch[c];
    end

    // ---------------------------------------------------------------- status

    // set wins over a read clear landing in the same cycle
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            high_warning_status <= RST_STAT;
        else if (conv_evt)
            high_warning_status <= (hs_clear ? 8'h00 : high_warning_status) | high_map;
        else if (hs_clear)
            high_warning_status <= 8'h00;
    end

    // hysteresis clear only at a conversion; reading leaves it alone
    always_comb
    begin
        next_overtemp_status = overtemp_status;
        if (conv_evt)
            next_overtemp_status = (overtemp_status & ~hyst_map) | ovt_map;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            overtemp_status <= RST_STAT;
        else
            overtemp_status <= next_overtemp_status;
    end

    // fault bits follow each conversion; bit 7 stays zero
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            sensor_fault_status <= RST_STAT;
        else if (conv_evt)
            sensor_fault_status <= {1'b0, fault_ch};
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            low_warning_o <= RST_STAT;
        else if (conv_evt)
            low_warning_o <= low_map;
        else if (ara_clear)
            low_warning_o <= 8'h00;
    end

    // ----------------------------------------------------------- alarm pins

    // warning latch: set at a conversion, cleared by high warning status read or response
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            alert_active <= 1'b0;
        else if (conv_evt && |((high_map | low_map) & ~alert_mask))
            alert_active <= 1'b1;
        else if (hs_clear || ara_clear)
            alert_active <= 1'b0;
    end

    // pins are open drain: level always low, the enable decides
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            alert_o      <= 1'b0;
            overt_o      <= 1'b0;
            sda_o        <= 1'b0;
            alert_oe_n_o <= 1'b1;
            overt_oe_n_o <= 1'b1;
        end
        else
        begin
            alert_o      <= 1'b0;
            overt_o      <= 1'b0;
            sda_o        <= 1'b0;
            alert_oe_n_o <= ~alert_active;
            overt_oe_n_o <= ~|(next_overtemp_status & ~overtemp_channel_mask);
        end
    end

    // ------------------------------------------------------------ registers

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            alert_mask            <= RST_MASK;
            overtemp_channel_mask <= RST_MASK;
        end
        else if (wr_pulse)
        begin
            if (pointer == REG_ALERT_MASK)
                alert_mask <= wr_data;
            if (pointer == REG_OVT_MASK)
                overtemp_channel_mask <= wr_data;
        end
    end

    always_comb
    begin
        unique case (pointer)
            REG_ALERT_MASK: read_data = alert_mask;
            REG_OVT_MASK:   read_data = overtemp_channel_mask;
            REG_HIGH_STAT:  read_data = high_warning_status;
            REG_OVT_STAT:   read_data = overtemp_status;
            REG_FAULT_STAT: read_data = sensor_fault_status;
            default:        read_data = UNMAPPED_DATA;
        endcase
    end

    // ------------------------------------------------------- two-wire slave

    tam_sync2 #(
        .W       (2),
        .RST_VAL (2'b11)
    ) u_pin_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i ({scl_i, sda_i}),
        .sync_o  (pins_sync)
    );

    assign scl_s      = pins_sync[1];
    assign sda_s      = pins_sync[0];
    assign scl_rise   = scl_s & ~scl_d;
    assign scl_fall   = ~scl_s & scl_d;
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
    assign byte_in    = {shreg[6:0], sda_s};

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // bytes are shifted in on scl rise; sda only changes after scl fall
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state       <= ST_IDLE;
            shreg       <= 8'h00;
            bitcnt      <= 4'h0;
            pointer     <= RST_POINTER;
            tx          <= 8'h00;
            rw          <= 1'b0;
            is_ara      <= 1'b0;
            ack_ok      <= 1'b0;
            ack_phase   <= 1'b0;
            master_nack <= 1'b0;
            sda_oe_n_o  <= 1'b1;
            wr_pulse    <= 1'b0;
            wr_data     <= 8'h00;
            hs_clear    <= 1'b0;
            ara_clear   <= 1'b0;
        end
        else
        begin
            wr_pulse  <= 1'b0;
            hs_clear  <= 1'b0;
            ara_clear <= 1'b0;
            if (start_cond)
            begin
                state      <= ST_ADDR;
                bitcnt     <= 4'h0;
                ack_phase  <= 1'b0;
                sda_oe_n_o <= 1'b1;
            end
            else if (stop_cond)
            begin
                state      <= ST_IDLE;
                sda_oe_n_o <= 1'b1;
            end
            else
            begin
                unique case (state)
                    ST_IDLE:
                        sda_oe_n_o <= 1'b1;
                    ST_ADDR, ST_CMD, ST_WDATA:
                        if (scl_rise)
                        begin
                            shreg  <= byte_in;
                            bitcnt <= bitcnt + 4'h1;
                            if (bitcnt == LAST_BIT)
                            begin
                                bitcnt <= 4'h0;
                                ack_ok <= 1'b1;
                                if (state == ST_ADDR)
                                begin
                                    rw     <= byte_in[0];
                                    is_ara <= 1'b0;
                                    tx     <= read_data;
                                    state  <= ST_ADDR_ACK;
                                    if (byte_in[7:1] != OWN_ADDR)
                                    begin
                                        // only a pending warning answers the response address
                                        is_ara <= 1'b1;
                                        tx     <= {OWN_ADDR, 1'b0};
                                        ack_ok <= (byte_in[7:1] == ARA_ADDR) && byte_in[0] && alert_active;
                                    end
                                end
                                else if (state == ST_CMD)
                                begin
                                    pointer <= byte_in;
                                    state   <= ST_CMD_ACK;
                                end
                                else
                                begin
                                    wr_data  <= byte_in;
                                    wr_pulse <= 1'b1;
                                    state    <= ST_WDATA_ACK;
                                end
                            end
                        end
                    ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK:
                        if (scl_fall)
                        begin
                            if (!ack_phase)
                            begin
                                ack_phase  <= 1'b1;
                                sda_oe_n_o <= ~ack_ok;
                            end
                            else
                            begin
                                ack_phase  <= 1'b0;
                                sda_oe_n_o <= 1'b1;
                                if (!ack_ok)
                                    state <= ST_IDLE;
                                else if (state == ST_ADDR_ACK && rw)
                                begin
                                    state      <= ST_RDATA;
                                    sda_oe_n_o <= tx[7];
                                    tx         <= {tx[6:0], 1'b0};
                                end
                                else
                                    state <= (state == ST_ADDR_ACK) ? ST_CMD : ST_WDATA;
                            end
                        end
                    ST_RDATA:
                        if (scl_rise)
                        begin
                            bitcnt <= bitcnt + 4'h1;
                            // released one read back as zero: a lower address won
                            if (is_ara && sda_oe_n_o && !sda_s)
                            begin
                                state  <= ST_IDLE;
                                bitcnt <= 4'h0;
                            end
                        end
                        else if (scl_fall)
                        begin
                            if (bitcnt == BYTE_BITS)
                            begin
                                bitcnt     <= 4'h0;
                                sda_oe_n_o <= 1'b1;
                                state      <= ST_RDATA_ACK;
                                ara_clear  <= is_ara;
                                hs_clear   <= !is_ara && (pointer == REG_HIGH_STAT);
                            end
                            else
                            begin
                                sda_oe_n_o <= tx[7];
                                tx         <= {tx[6:0], 1'b0};
                            end
                        end
                    ST_RDATA_ACK:
                        if (scl_rise)
                            master_nack <= sda_s;
                        else if (scl_fall)
                        begin
                            if (master_nack || is_ara)
                                state <= ST_IDLE;
                            else
                            begin
                                state      <= ST_RDATA;
                                sda_oe_n_o <= read_data[7];
                                tx         <= {read_data[6:0], 1'b0};
                            end
                        end
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

endmodule : tam_alarm_top

`default_nettype wire

// ---- logic/tam_pkg.sv ----
// package of the alarm status and mask block: register map, reset values,
// bit positions and the byte engine states.
// assumes the system clock clock_i at 200 MHz and the two-wire pins sampled on it.
`default_nettype none

package tam_pkg;

    localparam int unsigned NCH          = 8;
    localparam int unsigned NFAULT       = 7;

    // register offsets, reached through the command byte
    localparam logic [7:0]  REG_ALERT_MASK = 8'h42;
    localparam logic [7:0]  REG_OVT_MASK   = 8'h43;
    localparam logic [7:0]  REG_HIGH_STAT  = 8'h44;
    localparam logic [7:0]  REG_OVT_STAT   = 8'h45;
    localparam logic [7:0]  REG_FAULT_STAT = 8'h46;

    // reset values
    localparam logic [7:0]  RST_MASK       = 8'h00;
    localparam logic [7:0]  RST_STAT       = 8'h00;
    localparam logic [7:0]  RST_POINTER    = 8'h00;
    localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;

    // bit positions within the channel-ordered registers
    localparam int unsigned LOCAL_BIT      = 6;
    localparam int unsigned REMOTE7_BIT    = 7;

    // alert response address
    localparam logic [6:0]  ARA_ADDR       = 7'h19;

    // overtemperature hysteresis, degrees; applied by the conversion engine
    localparam int unsigned OVT_HYST_DEG   = 4;

    // bit count at which a byte is complete
    localparam logic [3:0]  BYTE_BITS      = 4'h8;
    localparam logic [3:0]  LAST_BIT       = 4'h7;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_ADDR      = 4'b0001,
        ST_ADDR_ACK  = 4'b0010,
        ST_CMD       = 4'b0011,
        ST_CMD_ACK   = 4'b0100,
        ST_WDATA     = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA     = 4'b0111,
        ST_RDATA_ACK = 4'b1000
    } tam_state_t;

endpackage : tam_pkg

`default_nettype wire

// ---- logic/tam_sync2.sv ----
// two-flop synchroniser for a group of independent levels.
// assumes each bit is a level that may change at any time relative to clock_i.
`timescale 1ns/1ps
`default_nettype none

module tam_sync2
    import tam_pkg::*;
#(
    parameter int unsigned    W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
)
(
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output var  logic [W-1:0] sync_o
);

    logic [W-1:0] meta;

    // first stage feeds the second stage only
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta   <= RST_VAL;
            sync_o <= RST_VAL;
        end
        else
        begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule : tam_sync2

`default_nettype wire

// ---- logic/tam_conv_cdc.sv ----
// hands one conversion's comparison results from the link clock to clock_i.
// assumes conversions are spaced by many link cycles; a new result before the
// previous toggle has been seen would overwrite the held words.
`timescale 1ns/1ps
`default_nettype none

module tam_conv_cdc
    import tam_pkg::*;
(
    input  wire logic              conv_clk_i,
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic              conv_done_i,
    input  wire logic [NCH-1:0]    high_cmp_i,
    input  wire logic [NCH-1:0]    low_cmp_i,
    input  wire logic [NCH-1:0]    ovt_cmp_i,
    input  wire logic [NCH-1:0]    ovt_hyst_i,
    input  wire logic [NFAULT-1:0] fault_i,
    output var  logic              conv_evt_o,
    output var  logic [NCH-1:0]    high_cmp_o,
    output var  logic [NCH-1:0]    low_cmp_o,
    output var  logic [NCH-1:0]    ovt_cmp_o,
    output var  logic [NCH-1:0]    ovt_hyst_o,
    output var  logic [NFAULT-1:0] fault_o
);

    logic conv_tgl;
    logic tgl_sync;
    logic tgl_seen;

    // link side: hold the words and flip the toggle in the same edge
    always_ff @(posedge conv_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            conv_tgl   <= 1'b0;
            high_cmp_o <= '0;
            low_cmp_o  <= '0;
            ovt_cmp_o  <= '0;
            ovt_hyst_o <= '0;
            fault_o    <= '0;
        end
        else if (conv_done_i)
        begin
            conv_tgl   <= ~conv_tgl;
            high_cmp_o <= high_cmp_i;
            low_cmp_o  <= low_cmp_i;
            ovt_cmp_o  <= ovt_cmp_i;
            ovt_hyst_o <= ovt_hyst_i;
            fault_o    <= fault_i;
        end
    end

    tam_sync2 #(
        .W       (1),
        .RST_VAL (1'b0)
    ) u_tgl_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i (conv_tgl),
        .sync_o  (tgl_sync)
    );

    // held words are stable long before the synchronised toggle moves
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tgl_seen   <= 1'b0;
            conv_evt_o <= 1'b0;
        end
        else
        begin
            tgl_seen   <= tgl_sync;
            conv_evt_o <= tgl_sync ^ tgl_seen;
        end
    end

endmodule : tam_conv_cdc

`default_nettype wire

// ---- bench/tam_alarm_chk.sv ----
// checker of the alarm pins and the two-wire data drive of tam_alarm_top.
// assumes conv_done_i lasts many clock_i cycles, so it is sampled here directly.
`timescale 1ns/1ps
`default_nettype none
module tam_alarm_chk
    import tam_pkg::*;
(
    input wire logic           clock_i,
    input wire logic           rst_i,
    input wire logic           conv_done_i,
    input wire logic           scl_i,
    input wire logic           sda_o,
    input wire logic           sda_oe_n_o,
    input wire logic           alert_o,
    input wire logic           alert_oe_n_o,
    input wire logic           overt_o,
    input wire logic           overt_oe_n_o,
    input wire logic [NCH-1:0] low_warning_o
);
    logic [7:0] since;
    // cycles since the last conversion pulse, saturating
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            since <= 8'hFF;
        else if (conv_done_i)
            since <= 8'h00;
        else if (since != 8'hFF)
            since <= since + 8'h01;
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    pin_level_a: assert property (!(sda_o | alert_o | overt_o))
        else $error("pin data not low");
    reset_release_a: assert property (disable iff (1'b0) rst_i |-> sda_oe_n_o && alert_oe_n_o && overt_oe_n_o)
        else $error("pins driven in reset");
    alert_set_a: assert property ($fell(alert_oe_n_o) |-> since < 8'h10)
        else $error("warning pin set off conversion");
    low_set_a: assert property ($changed(low_warning_o) && low_warning_o != '0 |-> since < 8'h10)
        else $error("low flags set off conversion");
    alert_clear_a: assert property ($rose(alert_oe_n_o) |-> !scl_i)
        else $error("warning pin cleared off bus byte");
    sda_drive_a: assert property ($fell(sda_oe_n_o) |-> !scl_i)
        else $error("data driven while clock high");
    sda_release_a: assert property ($rose(sda_oe_n_o) |-> !scl_i)
        else $error("data released while clock high");
    sda_hold_a: assert property ($fell(sda_oe_n_o) |=> !sda_oe_n_o [*8])
        else $error("data drive too short");
    cover property ($fell(overt_oe_n_o));
    cover property ($rose(alert_oe_n_o));
    cover property ($fell(sda_oe_n_o) ##[1:200] $rose(sda_oe_n_o));
endmodule : tam_alarm_chk
bind tam_alarm_top tam_alarm_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .conv_done_i(conv_done_i),
    .scl_i(scl_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o),
    .overt_o(overt_o), .overt_oe_n_o(overt_oe_n_o), .low_warning_o(low_warning_o));
`default_nettype wire

// ---- bench/tam_host.sv ----
// two-wire host master model: start, stop and nine-bit byte transfers.
// assumes the bench resolves the data wire with a pull-up; sh holds the last byte seen.
`timescale 1ns/1ps
`default_nettype none
module tam_host
(
    input  wire logic clock_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_low_o
);
    logic [8:0] sh;
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // data moves mid-phase, never together with the clock edge
    task automatic step(input logic c, input logic d);
        scl_o = c;
        repeat (5) @(posedge clock_i);
        #1;
        sda_low_o = !d;
        repeat (5) @(posedge clock_i);
        #1;
    endtask : step
    task automatic xfer(input logic [7:0] d);
        sh = {d, 1'b1};
        for (int i = 0; i < 9; i++)
        begin
            step(1'b0, sh[8]);
            step(1'b1, sh[8]);
            sh = {sh[7:0], sda_i};
        end
    endtask : xfer
    task automatic go(input logic [7:0] a);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        xfer(a);
    endtask : go
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : stop
endmodule : tam_host
`default_nettype wire

// ---- bench/tam_tb.sv ----
// self-checking bench of tam_alarm_top with the host model on the two-wire pins.
// assumes the checker is bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tam_pkg::*;
    localparam logic [6:0] ADDR = 7'h4D;  // value arbitrary
    logic              clock_i = 1'b0;
    logic              conv_clk = 1'b0;
    logic              rst = 1'b0;
    logic              done = 1'b0;
    logic [NCH-1:0]    hi = '0, lo = '0, ov = '0, hy = '0, low_w;
    logic [NFAULT-1:0] flt = '0;
    logic              scl, host_low, sda_oe_n, alert_n, overt_n;
    logic [7:0]        q;
    int                fail_count = 0, total_checks = 0, cyc = 0;
    wire logic         sda = sda_oe_n & !host_low;
    always #2.5 clock_i = !clock_i;
    always #32 conv_clk = !conv_clk;
    tam_alarm_top #(.OWN_ADDR(ADDR)) u_dut (.clock_i(clock_i), .rst_i(rst), .conv_clk_i(conv_clk),
        .conv_done_i(done), .high_cmp_i(hi), .low_cmp_i(lo), .ovt_cmp_i(ov), .ovt_hyst_i(hy), .fault_i(flt),
        .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n), .alert_o(), .alert_oe_n_o(alert_n),
        .overt_o(), .overt_oe_n_o(overt_n), .low_warning_o(low_w));
    tam_host u_host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    task automatic conclude();
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] cmd);
        u_host.go({ADDR, 1'b0});
        u_host.xfer(cmd);
        u_host.go({ADDR, 1'b1});
        u_host.xfer(8'hFF);
        q = u_host.sh[8:1];
        u_host.stop();
    endtask : rd
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        u_host.go({ADDR, 1'b0});
        u_host.xfer(cmd);
        u_host.xfer(d);
        u_host.stop();
    endtask : wr
    task automatic conv(input logic [7:0] h, input logic [7:0] l, input logic [7:0] o, input logic [7:0] y);
        @(posedge conv_clk);
        #1;
        {hi, lo, ov, hy} = {h, l, o, y};
        done = 1'b1;
        @(posedge conv_clk);
        #1;
        done = 1'b0;
        repeat (4) @(posedge conv_clk);
        #1;
    endtask : conv
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fail_count++;
            conclude();
        end
    end
    initial
    begin
        // a real edge on reset, so the asynchronous branches fire before the first clock
        #1;
        rst = 1'b1;
        repeat (12) @(posedge clock_i);
        #1;
        rst = 1'b0;
        for (int a = 8'h42; a <= 8'h47; a++)
        begin
            rd(a[7:0]);
            chk(q, 8'h00);
        end
        wr(REG_OVT_MASK, 8'h40);
        rd(REG_OVT_MASK);
        chk(q, 8'h40);
        flt = 7'h45;
        conv(8'h00, 8'h00, 8'h01, 8'h00);
        chk({7'h00, overt_n}, 8'h01);
        rd(REG_FAULT_STAT);
        chk(q, 8'h45);
        wr(REG_OVT_MASK, 8'h00);
        chk({7'h00, overt_n}, 8'h00);
        conv(8'h00, 8'h00, 8'h00, 8'h00);
        rd(REG_OVT_STAT);
        chk(q, 8'h40);
        chk({7'h00, overt_n}, 8'h00);
        conv(8'h00, 8'h00, 8'h00, 8'h01);
        chk({7'h00, overt_n}, 8'h01);
        // channels 7 and 1 land on bits 7 and 0
        conv(8'h82, 8'h00, 8'h00, 8'h00);
        chk({7'h00, alert_n}, 8'h00);
        rd(REG_HIGH_STAT);
        chk(q, 8'h81);
        chk({7'h00, alert_n}, 8'h01);
        rd(REG_HIGH_STAT);
        chk(q, 8'h00);
        conv(8'h82, 8'h00, 8'h00, 8'h00);
        chk({7'h00, alert_n}, 8'h00);
        // a lower address pulls the first data bit low; this device backs off
        u_host.go({ARA_ADDR, 1'b1});
        u_host.xfer(8'h7F);
        u_host.stop();
        chk({7'h00, alert_n}, 8'h00);
        u_host.go({ARA_ADDR, 1'b1});
        chk({7'h00, u_host.sh[0]}, 8'h00);
        u_host.xfer(8'hFF);
        chk(u_host.sh[8:1], {ADDR, 1'b0});
        u_host.stop();
        chk({7'h00, alert_n}, 8'h01);
        u_host.go({ARA_ADDR, 1'b1});
        chk({7'h00, u_host.sh[0]}, 8'h01);
        u_host.stop();
        conv(8'h00, 8'h01, 8'h00, 8'h00);
        chk(low_w, 8'h40);
        chk({7'h00, alert_n}, 8'h00);
        u_host.go({ARA_ADDR, 1'b1});
        u_host.xfer(8'hFF);
        u_host.stop();
        chk(low_w, 8'h00);
        rd(REG_HIGH_STAT);
        chk(q, 8'h81);
        wr(REG_ALERT_MASK, 8'h40);
        conv(8'h00, 8'h01, 8'h00, 8'h00);
        chk({7'h00, alert_n}, 8'h01);
        conclude();
    end
endmodule : testbench
`default_nettype wire
